// ==== logic/mirf_consts.vh ====
// register map and field constants for the mac interrupt mask and receive filter registers
`ifndef MIRF_CONSTS_VH
`define MIRF_CONSTS_VH

// register byte offsets (word aligned)
`define MIRF_OFS_STATUS_UNMASKED 8'h00
`define MIRF_OFS_STATUS_MASKED   8'h04
`define MIRF_OFS_ENABLE_SET      8'h08
`define MIRF_OFS_ENABLE_CLEAR    8'h0C
`define MIRF_OFS_RX_FILTER       8'h10

// interrupt source bit positions
`define MIRF_BIT_STATS       0
`define MIRF_BIT_HOST_ERROR  1
`define MIRF_IRQ_WIDTH       2

// receive filter register field positions
`define MIRF_BIT_KEEP_FCS    30
`define MIRF_BIT_QOS_EN      29
`define MIRF_BIT_SINGLE_BUF  28
`define MIRF_BIT_COPY_CTRL   24
`define MIRF_BIT_COPY_SHORT  23
`define MIRF_BIT_COPY_ERR    22
`define MIRF_BIT_COPY_ALL    21
`define MIRF_PROM_CH_HI      18
`define MIRF_PROM_CH_LO      16
`define MIRF_BIT_BCAST_EN    13
`define MIRF_BCAST_CH_HI     10
`define MIRF_BCAST_CH_LO     8
`define MIRF_BIT_MCAST_EN    5
`define MIRF_MCAST_CH_HI     2
`define MIRF_MCAST_CH_LO     0

// writable bits of the receive filter register, everything else reads zero
`define MIRF_RX_FILTER_WMASK 32'h71E72727
`define MIRF_RX_FILTER_RESET 32'h00000000
`define MIRF_IRQ_RESET       2'h0

// zero words for read data, length and status padding
`define MIRF_WORD_ZERO       32'h00000000
`define MIRF_LEN_ZERO        16'h0000
`define MIRF_IRQ_PAD_ZERO    30'h00000000

// length of the frame check sequence in bytes
`define MIRF_FCS_BYTES       16'h0004

`endif

// ==== logic/mirf_sync.v ====
// two-flop synchroniser for a bundle of level inputs
`timescale 1ns/10ps
module mirf_sync #(
    parameter WIDTH = 2
) (
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] meta_q;
reg [WIDTH-1:0] sync_q;

// first stage feeds only the second stage
always @(posedge ref_clk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
    begin
        meta_q <= {WIDTH{1'b0}};
        sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_q <= async_i;
        sync_q <= meta_q;
    end
end

assign sync_o = sync_q;

endmodule // mirf_sync

// ==== logic/mirf_regs.v ====
// mac interrupt mask registers and receive filter configuration register on classic wishbone
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`include "mirf_consts.vh"

//Contract
//(RULE1) masked status bit 1 shows host error pending gated by its enable.
//(RULE2) masked status bit 0 shows stats pending gated; bits 31..2 read zero.
//(RULE3) writing one to enable-set bit 1 enables host error interrupt; zero ignored.
//(RULE4) writing one to enable-set bit 0 enables stats interrupt; zero ignored.
//(RULE5) writing one to enable-clear bit 1 disables host error interrupt; zero ignored.
//(RULE6) writing one to enable-clear bit 0 disables stats interrupt; zero ignored.
//(RULE7) an unmasked read of both pending indications is provided.
//(RULE8) masked equals pending AND enable; set and clear registers read current enables.
//(RULE9) keep-fcs zero: fcs dropped and excluded from descriptor length.
//(RULE10) keep-fcs one: fcs written to memory and counted in length.
//(RULE11) bit 29 enables receive quality of service when set.
//(RULE12) bit 28 selects single-buffer frames; length holds full count to 65535.
//(RULE13) copy enables, channel selects and accept enables sit at their fixed bits.
//(RULE14) writable filter fields reset to zero; reserved bits read zero.
module mirf_regs (
    input wire ref_clk_i,
    input wire sys_rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // raw interrupt sources from the mac (asynchronous levels)
    input wire host_error_pending_i,
    input wire stats_pending_i,
    output wire irq_o,
    // receive configuration towards the dma and filter datapath
    output wire keep_rx_fcs_o,
    output wire rx_qos_enable_o,
    output wire single_buffer_frames_o,
    output wire copy_control_frames_o,
    output wire copy_short_frames_o,
    output wire copy_errored_frames_o,
    output wire copy_unmatched_frames_o,
    output wire [2:0] promiscuous_channel_select_o,
    output wire broadcast_accept_enable_o,
    output wire [2:0] broadcast_channel_select_o,
    output wire multicast_accept_enable_o,
    output wire [2:0] multicast_channel_select_o,
    // descriptor length computation for a completed frame
    input wire rx_frame_done_i,
    input wire [15:0] rx_frame_len_i,
    output wire rx_desc_len_valid_o,
    output wire [15:0] rx_desc_len_o
);

// byte-lane merge of write data into an old register value
function [31:0] mirf_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] sel;
    integer i;
    begin
        mirf_merge = old_val;
        for (i = 0; i < 4; i = i + 1)
        begin
            if (sel[i])
                mirf_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
    end
endfunction

// zero-extend the two-bit interrupt vector to a bus word
function [31:0] mirf_irq_word;
    input [`MIRF_IRQ_WIDTH-1:0] bits;
    begin
        mirf_irq_word = {`MIRF_IRQ_PAD_ZERO, bits};
    end
endfunction

// word address match for one register
function mirf_hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
        mirf_hit = (adr == ofs);
    end
endfunction

// reserved filter bits forced to zero
function [31:0] mirf_filter_clean;
    input [31:0] word;
    begin
        mirf_filter_clean = word & `MIRF_RX_FILTER_WMASK;
    end
endfunction

// descriptor length: whole count with the fcs kept, else less the fcs, floored at zero
function [15:0] mirf_desc_len;
    input [15:0] len;
    input keep;
    begin
        // (RULE10) fcs counted when kept
        if (keep)
            mirf_desc_len = len;
        // (RULE9) fcs excluded, short counts floor at zero
        else if (len > `MIRF_FCS_BYTES)
            mirf_desc_len = len - `MIRF_FCS_BYTES;
        else
            mirf_desc_len = `MIRF_LEN_ZERO;
    end
endfunction

wire [`MIRF_IRQ_WIDTH-1:0] pend_sync;
reg [`MIRF_IRQ_WIDTH-1:0] pend_q;
reg [`MIRF_IRQ_WIDTH-1:0] pend_d;
reg [`MIRF_IRQ_WIDTH-1:0] enable_q;
reg [`MIRF_IRQ_WIDTH-1:0] enable_d;
reg [31:0] rx_filter_q;
reg [31:0] rx_filter_d;
reg ack_q;
reg [31:0] rdata_q;
reg [31:0] rdata_d;
reg len_valid_q;
reg [15:0] len_q;
wire [`MIRF_IRQ_WIDTH-1:0] masked;
wire bus_req;
wire wr_en;
wire wr_lane0;
wire wr_status;
wire wr_set;
wire wr_clear;
wire wr_filter;
wire rd_take;
wire [31:0] raw_word;
wire [31:0] masked_word;
wire [31:0] enable_word;

// pending sources come from another clock region
mirf_sync #(
    .WIDTH(`MIRF_IRQ_WIDTH)
) u_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({host_error_pending_i, stats_pending_i}),
    .sync_o(pend_sync)
);

// a request is taken once, the cycle ack is low
assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
assign wr_en = bus_req & wb_we_i;
assign wr_lane0 = wr_en & wb_sel_i[0];
assign rd_take = bus_req & ~wb_we_i;

// per-register write strobes, mask and status need byte lane 0
assign wr_status = wr_lane0 & mirf_hit(wb_adr_i, `MIRF_OFS_STATUS_UNMASKED);
assign wr_set = wr_lane0 & mirf_hit(wb_adr_i, `MIRF_OFS_ENABLE_SET);
assign wr_clear = wr_lane0 & mirf_hit(wb_adr_i, `MIRF_OFS_ENABLE_CLEAR);
assign wr_filter = wr_en & mirf_hit(wb_adr_i, `MIRF_OFS_RX_FILTER);

// sticky unmasked status: set by a pending level, write one clears, set wins
always @*
begin
    pend_d = pend_q;
    if (wr_status)
        pend_d = pend_q & ~wb_dat_i[`MIRF_IRQ_WIDTH-1:0];
    // (RULE7) raw pending capture
    pend_d = pend_d | pend_sync;
end

// enable mask: write one to set or clear, zeros leave it alone
always @*
begin
    enable_d = enable_q;
    // (RULE3) host enable set
    if (wr_set && wb_dat_i[`MIRF_BIT_HOST_ERROR])
        enable_d[`MIRF_BIT_HOST_ERROR] = 1'b1;
    // (RULE4) stats enable set
    if (wr_set && wb_dat_i[`MIRF_BIT_STATS])
        enable_d[`MIRF_BIT_STATS] = 1'b1;
    // (RULE5) host enable clear
    if (wr_clear && wb_dat_i[`MIRF_BIT_HOST_ERROR])
        enable_d[`MIRF_BIT_HOST_ERROR] = 1'b0;
    // (RULE6) stats enable clear
    if (wr_clear && wb_dat_i[`MIRF_BIT_STATS])
        enable_d[`MIRF_BIT_STATS] = 1'b0;
end

// receive filter register write, only writable bits take data
always @*
begin
    rx_filter_d = rx_filter_q;
    // (RULE14) reserved bits stay zero
    if (wr_filter)
        rx_filter_d = mirf_filter_clean(mirf_merge(rx_filter_q, wb_dat_i, wb_sel_i));
end

// (RULE8) masked view is pending and enable
assign masked = pend_q & enable_q;

// bus words of the status and mask views
assign raw_word = mirf_irq_word(pend_q);
assign masked_word = mirf_irq_word(masked);
assign enable_word = mirf_irq_word(enable_q);

// read multiplexer, unmapped addresses read zero
always @*
begin
    rdata_d = `MIRF_WORD_ZERO;
    case (wb_adr_i)
        // (RULE7) unmasked read
        `MIRF_OFS_STATUS_UNMASKED: rdata_d = raw_word;
        // (RULE1) masked host bit, (RULE2) upper bits zero
        `MIRF_OFS_STATUS_MASKED: rdata_d = masked_word;
        // (RULE8) both mask views
        `MIRF_OFS_ENABLE_SET: rdata_d = enable_word;
        `MIRF_OFS_ENABLE_CLEAR: rdata_d = enable_word;
        `MIRF_OFS_RX_FILTER: rdata_d = mirf_filter_clean(rx_filter_q);
        default: rdata_d = `MIRF_WORD_ZERO;
    endcase
end

// sticky pending status register
always @(posedge ref_clk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
        pend_q <= `MIRF_IRQ_RESET;
    else
        pend_q <= pend_d;
end

// interrupt enable mask register
always @(posedge ref_clk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
        enable_q <= `MIRF_IRQ_RESET;
    else
        enable_q <= enable_d;
end

// receive filter configuration register
always @(posedge ref_clk_i or posedge sys_rst_i)
begin
    // (RULE14) filter fields reset
    if (sys_rst_i)
        rx_filter_q <= `MIRF_RX_FILTER_RESET;
    else
        rx_filter_q <= rx_filter_d;
end

// bus answer: one-cycle ack, read data held until the next read
always @(posedge ref_clk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
    begin
        ack_q <= 1'b0;
        rdata_q <= `MIRF_WORD_ZERO;
    end
    else
    begin
        ack_q <= bus_req;
        if (rd_take)
            rdata_q <= rdata_d;
    end
end

assign wb_ack_o = ack_q;
assign wb_dat_o = rdata_q;

// level interrupt while any masked status bit is set
assign irq_o = |masked;

// (RULE13) field placement towards the datapath
assign copy_control_frames_o = rx_filter_q[`MIRF_BIT_COPY_CTRL];
assign copy_short_frames_o = rx_filter_q[`MIRF_BIT_COPY_SHORT];
assign copy_errored_frames_o = rx_filter_q[`MIRF_BIT_COPY_ERR];
assign copy_unmatched_frames_o = rx_filter_q[`MIRF_BIT_COPY_ALL];
assign promiscuous_channel_select_o = rx_filter_q[`MIRF_PROM_CH_HI:`MIRF_PROM_CH_LO];
assign broadcast_accept_enable_o = rx_filter_q[`MIRF_BIT_BCAST_EN];
assign broadcast_channel_select_o = rx_filter_q[`MIRF_BCAST_CH_HI:`MIRF_BCAST_CH_LO];
assign multicast_accept_enable_o = rx_filter_q[`MIRF_BIT_MCAST_EN];
assign multicast_channel_select_o = rx_filter_q[`MIRF_MCAST_CH_HI:`MIRF_MCAST_CH_LO];

// (RULE11) quality of service enable
assign rx_qos_enable_o = rx_filter_q[`MIRF_BIT_QOS_EN];
// (RULE12) single buffer per frame
assign single_buffer_frames_o = rx_filter_q[`MIRF_BIT_SINGLE_BUF];
// (RULE9) fcs keep select
assign keep_rx_fcs_o = rx_filter_q[`MIRF_BIT_KEEP_FCS];

// length valid pulse one cycle after frame done
always @(posedge ref_clk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
        len_valid_q <= 1'b0;
    else
        len_valid_q <= rx_frame_done_i;
end

// descriptor length latched with each completed frame
always @(posedge ref_clk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
        len_q <= `MIRF_LEN_ZERO;
    else if (rx_frame_done_i)
        len_q <= mirf_desc_len(rx_frame_len_i, rx_filter_q[`MIRF_BIT_KEEP_FCS]);
end

// (RULE12) sixteen-bit length holds counts up to 65535
assign rx_desc_len_o = len_q;
assign rx_desc_len_valid_o = len_valid_q;

endmodule // mirf_regs

// ==== sim/mirf_regs_sva.sv ====
// assertions on the register bus, status reads and length ports of mirf_regs
`timescale 1ns/10ps
`include "mirf_consts.vh"
module mirf_regs_sva (
    input logic ref_clk_i,
    input logic sys_rst_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [7:0] wb_adr_i,
    input logic [31:0] wb_dat_o,
    input logic wb_ack_o,
    input logic keep_rx_fcs_o,
    input logic rx_qos_enable_o,
    input logic single_buffer_frames_o,
    input logic rx_frame_done_i,
    input logic [15:0] rx_frame_len_i,
    input logic rx_desc_len_valid_o,
    input logic [15:0] rx_desc_len_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // read answer qualifier
    wire rd_ack = wb_ack_o && !wb_we_i;
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_masked_zero; rd_ack && wb_adr_i == `MIRF_OFS_STATUS_MASKED |-> wb_dat_o[31:2] == 30'h0; endproperty
    a_masked_zero: assert property (p_masked_zero) else $error("masked status upper bits set");
    property p_raw_zero; rd_ack && wb_adr_i == `MIRF_OFS_STATUS_UNMASKED |-> wb_dat_o[31:2] == 30'h0; endproperty
    a_raw_zero: assert property (p_raw_zero) else $error("raw status upper bits set");
    property p_filt_rsvd; rd_ack && wb_adr_i == `MIRF_OFS_RX_FILTER |-> (wb_dat_o & ~`MIRF_RX_FILTER_WMASK) == 32'h0;
    endproperty
    a_filt_rsvd: assert property (p_filt_rsvd) else $error("filter reserved bits set");
    property p_filt_bits; rd_ack && wb_adr_i == `MIRF_OFS_RX_FILTER
        |-> wb_dat_o[30:28] == {keep_rx_fcs_o, rx_qos_enable_o, single_buffer_frames_o}; endproperty
    a_filt_bits: assert property (p_filt_bits) else $error("filter bits differ from outputs");
    property p_len_keep; rx_frame_done_i && keep_rx_fcs_o |=> rx_desc_len_o == $past(rx_frame_len_i); endproperty
    a_len_keep: assert property (p_len_keep) else $error("length with fcs wrong");
    property p_len_drop; rx_frame_done_i && !keep_rx_fcs_o && rx_frame_len_i >= 16'h0004
        |=> rx_desc_len_o == $past(rx_frame_len_i) - 16'h0004; endproperty
    a_len_drop: assert property (p_len_drop) else $error("length without fcs wrong");
    property p_len_valid; rx_desc_len_valid_o == $past(rx_frame_done_i); endproperty
    a_len_valid: assert property (p_len_valid) else $error("length valid not one cycle after done");
    c_masked: cover property (rd_ack && wb_adr_i == `MIRF_OFS_STATUS_MASKED && wb_dat_o[1]);
    c_keep: cover property (rx_frame_done_i && keep_rx_fcs_o);
    c_drop: cover property (rx_frame_done_i && !keep_rx_fcs_o);
endmodule // mirf_regs_sva
bind mirf_regs mirf_regs_sva u_sva (.ref_clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .keep_rx_fcs_o, .rx_qos_enable_o, .single_buffer_frames_o, .rx_frame_done_i,
    .rx_frame_len_i, .rx_desc_len_valid_o, .rx_desc_len_o);

// ==== sim/mirf_regs_bench.sv ====
// self-checking bench for the mirf_regs register block
`timescale 1ns/10ps
`include "mirf_consts.vh"
module mirf_regs_bench;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, host = 1'b0, stat = 1'b0, done = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [15:0] flen = 16'h0000, dlen;
    logic ack, irq, dval, keep, qos, sbuf, cc, cs, ce, cu, be, me;
    logic [2:0] pch, bch, mch;
    int failures = 0;
    int compares = 0;
    // 100 MHz clock
    always #5 ref_clk_i = ~ref_clk_i;
    mirf_regs dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .host_error_pending_i(host), .stats_pending_i(stat), .irq_o(irq), .keep_rx_fcs_o(keep),
        .rx_qos_enable_o(qos), .single_buffer_frames_o(sbuf), .copy_control_frames_o(cc),
        .copy_short_frames_o(cs), .copy_errored_frames_o(ce), .copy_unmatched_frames_o(cu),
        .promiscuous_channel_select_o(pch), .broadcast_accept_enable_o(be), .broadcast_channel_select_o(bch),
        .multicast_accept_enable_o(me), .multicast_channel_select_o(mch), .rx_frame_done_i(done),
        .rx_frame_len_i(flen), .rx_desc_len_valid_o(dval), .rx_desc_len_o(dlen));
    // verdict and end of run
    task automatic final_report;
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // compare and count
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle, held until ack is sampled high at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            failures++;
            final_report;
        end
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, q, exp);
    endtask
    // interrupt level seen mid-cycle
    task automatic irq_chk(input logic exp);
        @(negedge ref_clk_i);
        check("irq", {31'h0, irq}, {31'h0, exp});
        @(posedge ref_clk_i);
    endtask
    // one completed frame and its descriptor length
    task automatic frame(input logic [15:0] len, input logic [15:0] exp);
        done <= 1'b1;
        flen <= len;
        @(posedge ref_clk_i);
        done <= 1'b0;
        @(negedge ref_clk_i);
        check("desc_len", {15'h0, dval, dlen}, {16'h0001, exp});
        @(posedge ref_clk_i);
    endtask
    // main sequence
    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(`MIRF_OFS_RX_FILTER, "filter_reset", 32'h0);
        rd(`MIRF_OFS_ENABLE_SET, "enable_reset", 32'h0);
        bus(1'b1, `MIRF_OFS_RX_FILTER, 32'hFFFFFFFF);
        rd(`MIRF_OFS_RX_FILTER, "filter_rw", 32'h71E72727);
        check("cfg_out", {keep, qos, sbuf, cc, cs, ce, cu, pch, be, bch, me, mch}, 32'h0003FFFF);
        frame(16'h0064, 16'h0064);
        bus(1'b1, `MIRF_OFS_RX_FILTER, 32'h0);
        frame(16'h0064, 16'h0060);
        frame(16'h0002, 16'h0000);
        bus(1'b1, `MIRF_OFS_ENABLE_SET, 32'h2);
        rd(`MIRF_OFS_ENABLE_SET, "en_host", 32'h2);
        bus(1'b1, `MIRF_OFS_ENABLE_SET, 32'h0);
        rd(`MIRF_OFS_ENABLE_CLEAR, "en_hold", 32'h2);
        bus(1'b1, `MIRF_OFS_ENABLE_SET, 32'h1);
        rd(`MIRF_OFS_ENABLE_SET, "en_both", 32'h3);
        host <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rd(`MIRF_OFS_STATUS_UNMASKED, "raw_host", 32'h2);
        rd(`MIRF_OFS_STATUS_MASKED, "masked_host", 32'h2);
        irq_chk(1'b1);
        bus(1'b1, `MIRF_OFS_ENABLE_CLEAR, 32'h2);
        rd(`MIRF_OFS_STATUS_MASKED, "masked_off", 32'h0);
        irq_chk(1'b0);
        stat <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rd(`MIRF_OFS_STATUS_MASKED, "masked_stat", 32'h1);
        irq_chk(1'b1);
        bus(1'b1, `MIRF_OFS_ENABLE_CLEAR, 32'h0);
        rd(`MIRF_OFS_ENABLE_SET, "clr_zero", 32'h1);
        bus(1'b1, `MIRF_OFS_ENABLE_CLEAR, 32'h1);
        rd(`MIRF_OFS_ENABLE_SET, "clr_stat", 32'h0);
        host <= 1'b0;
        stat <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        bus(1'b1, `MIRF_OFS_STATUS_UNMASKED, 32'h3);
        rd(`MIRF_OFS_STATUS_UNMASKED, "raw_clear", 32'h0);
        rd(8'h20, "unmapped", 32'h0);
        // mid-run reset after the registers were written
        bus(1'b1, `MIRF_OFS_RX_FILTER, 32'hFFFFFFFF);
        bus(1'b1, `MIRF_OFS_ENABLE_SET, 32'h3);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(`MIRF_OFS_RX_FILTER, "filter_rerst", 32'h0);
        rd(`MIRF_OFS_ENABLE_CLEAR, "en_rerst", 32'h0);
        // byte lane 1 only: filter byte 1 lands, mask writes need lane 0
        sel <= 4'h2;
        bus(1'b1, `MIRF_OFS_RX_FILTER, 32'hFFFFFFFF);
        bus(1'b1, `MIRF_OFS_ENABLE_SET, 32'h3);
        sel <= 4'hF;
        rd(`MIRF_OFS_RX_FILTER, "filter_lane1", 32'h00002700);
        check("bcast_out", {28'h0, be, bch}, 32'h0000000F);
        rd(`MIRF_OFS_ENABLE_SET, "en_lane0", 32'h0);
        final_report;
    end
endmodule // mirf_regs_bench
